// file: design/phase_offset_lock_monitor.sv
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Phase offset and lock-loss error posting exist only when the option is fitted; the status loss count is kept either way.
// - Offset accepted from minus to plus two pi; extremes clamp to ends.
// - Offset resets to zero and is held only in volatile flip-flops.
// - Standard shapes rise through zero at phase zero.
// - Arbitrary waveforms start at the first loaded sample at phase zero.
// - Offset and burst start phase are separate and independent.
// - Offset readback always in radians.
// - Reference command zeroes present phase, offset value unchanged.
// - Reference command has no readback.
// - Lock-loss reporting enable, default off, volatile.
// - Enabled and lock lost posts error code 580.
// - Enable reads back 0 when off, 1 when on.
module phase_offset_lock_monitor #(
  parameter bit OPTION_FITTED = 1'b1,
  parameter int ARB_W = 14,
  parameter int SAMPLE_W = 12
) (
  input wire logic clock, // 250 MHz system clock
  input wire logic nrst, // Sync reset, active low
  input wire phase_lock_pkg::avmm_req_t avReq, // Avalon-MM request
  output phase_lock_pkg::avmm_rsp_t avRsp, // Avalon-MM response
  input wire logic lockDetect, // Loop lock pin, high when locked
  output logic [31:0] wavePhase, // Output phase word
  output logic [ARB_W-1:0] arbAddr, // Arbitrary memory address
  output logic signed [SAMPLE_W-1:0] sample, // Square, triangle, ramp sample
  output phase_lock_pkg::wave_kind_t waveKind, // Selected shape
  output logic signed [9:0] burstPhase, // Burst start phase, degrees
  output logic errPost, // Error post strobe
  output logic [9:0] errCode // Posted error code
);
  typedef enum logic [0:0]
  {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  bus_state_t busState;
  bus_state_t next_busState;
  logic unlockErrEnable;
  logic signed [19:0] phaseRad;
  logic [31:0] freqInc;
  logic [31:0] acc;
  logic [31:0] refPoint;
  logic [31:0] readWord;
  logic [7:0] lossCount;
  logic lockSync;
  logic lockPrev;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Bus slave: one wait cycle, answer registered
  wire busReq = avReq.read | avReq.write;
  wire take = (busState == BUS_ACK);
  wire wrTake = take & avReq.write;
  wire selCtrl = (avReq.address == phase_lock_pkg::OFF_CTRL);
  wire selRad = (avReq.address == phase_lock_pkg::OFF_PHASE_RAD);
  wire selDeg = (avReq.address == phase_lock_pkg::OFF_PHASE_DEG);
  wire selBurst = (avReq.address == phase_lock_pkg::OFF_BURST_PHASE);
  wire selFreq = (avReq.address == phase_lock_pkg::OFF_FREQ_INC);
  wire selStat = (avReq.address == phase_lock_pkg::OFF_STATUS);

  assign next_busState = (busState == BUS_IDLE && busReq) ? BUS_ACK : BUS_IDLE;
  assign avRsp.waitrequest = ~take;
  assign avRsp.readdata = readWord;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      busState <= BUS_IDLE;
    end
    else
    begin
      busState <= next_busState;
    end
  end

  // Readback words
  wire [31:0] radWord = 32'(phaseRad);
  wire [31:0] ctrlWord = {27'h0000000, waveKind, 1'b0, unlockErrEnable};
  wire [31:0] burstWord = 32'(burstPhase);
  wire [31:0] statWord = {16'h0000, lossCount, 6'h00, OPTION_FITTED, lockSync};
  wire [31:0] next_readWord = selCtrl ? ctrlWord
                            : (selRad | selDeg) ? radWord
                            : selBurst ? burstWord
                            : selFreq ? freqInc
                            : selStat ? statWord
                            : 32'h00000000;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      readWord <= 32'h00000000;
    end
    else if (busState == BUS_IDLE && avReq.read)
    begin
      readWord <= next_readWord;
    end
  end

  // Control register
  wire [31:0] ctrlMerged = merge(ctrlWord, avReq.writedata, avReq.byteenable);
  wire ctrlWr = wrTake & selCtrl;
  wire refTake = ctrlWr & ctrlMerged[phase_lock_pkg::CTRL_REF_BIT] & OPTION_FITTED;
  wire [2:0] kindField = ctrlMerged[phase_lock_pkg::CTRL_KIND_LSB +: 3];
  wire kindOk = (kindField <= 3'(phase_lock_pkg::WAVE_ARB));

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      unlockErrEnable <= phase_lock_pkg::RST_UNLOCK_EN;
      waveKind <= phase_lock_pkg::WAVE_SINE;
    end
    else if (ctrlWr)
    begin
      unlockErrEnable <= ctrlMerged[phase_lock_pkg::CTRL_UNLOCK_EN_BIT] & OPTION_FITTED;
      if (kindOk)
      begin
        waveKind <= phase_lock_pkg::wave_kind_t'(kindField);
      end
    end
  end

  // Phase offset, radians or degrees by address
  wire [31:0] phaseMerged = merge(radWord, avReq.writedata, avReq.byteenable);
  wire phaseWr = wrTake & (selRad | selDeg) & OPTION_FITTED;
  logic signed [19:0] convRad;

  phase_convert u_convert (
    .word(phaseMerged),
    .isDeg(selDeg),
    .rad(convRad)
  );

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      phaseRad <= phase_lock_pkg::RST_PHASE_RAD;
    end
    else if (phaseWr)
    begin
      phaseRad <= convRad;
    end
  end

  // Burst phase lives in its own register
  wire [31:0] burstMerged = merge(burstWord, avReq.writedata, avReq.byteenable);

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      burstPhase <= phase_lock_pkg::RST_BURST_PHASE;
    end
    else if (wrTake & selBurst)
    begin
      burstPhase <= burstMerged[9:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      freqInc <= phase_lock_pkg::RST_FREQ_INC;
    end
    else if (wrTake & selFreq)
    begin
      freqInc <= merge(freqInc, avReq.writedata, avReq.byteenable);
    end
  end

  // Accumulator never restarts; reference and offset only shift the view
  // Both factors at 32 bits so the product is not cut to the offset's width
  wire signed [31:0] radWide = 32'(phaseRad);
  wire signed [31:0] turnScale = $signed(32'(phase_lock_pkg::TURN_PER_RAD));
  wire [31:0] offTurn = radWide * turnScale; // Wraps modulo one turn
  wire [31:0] relPhase = acc - refPoint;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      acc <= 32'h00000000;
      refPoint <= 32'h00000000;
    end
    else
    begin
      acc <= acc + freqInc;
      if (refTake)
      begin
        refPoint <= acc;
      end
    end
  end

  // Shapes: phase zero is the rising zero crossing
  wire [31:0] next_wavePhase = relPhase + offTurn;
  wire [SAMPLE_W-2:0] rise = next_wavePhase[29 -: SAMPLE_W-1];
  wire [SAMPLE_W-2:0] quarter = next_wavePhase[30] ? ~rise : rise;
  wire signed [SAMPLE_W-1:0] triMag = $signed({1'b0, quarter});
  wire signed [SAMPLE_W-1:0] triVal = next_wavePhase[31] ? -triMag : triMag;
  wire signed [SAMPLE_W-1:0] sqVal = next_wavePhase[31] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
                                                     : {1'b0, {(SAMPLE_W-1){1'b1}}};
  wire signed [SAMPLE_W-1:0] rampVal = next_wavePhase[31 -: SAMPLE_W];
  logic signed [SAMPLE_W-1:0] next_sample;

  always_comb
  begin
    case (waveKind)
      phase_lock_pkg::WAVE_SQUARE: next_sample = sqVal;
      phase_lock_pkg::WAVE_TRI: next_sample = triVal;
      phase_lock_pkg::WAVE_RAMP: next_sample = rampVal;
      default: next_sample = '0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wavePhase <= 32'h00000000;
      arbAddr <= '0;
      sample <= '0;
    end
    else
    begin
      wavePhase <= next_wavePhase;
      arbAddr <= next_wavePhase[31 -: ARB_W];
      sample <= next_sample;
    end
  end

  // Lock monitor
  sync2 #(
    .WIDTH(1)
  ) u_lockSync (
    .clock(clock),
    .nrst(nrst),
    .din(lockDetect),
    .dout(lockSync)
  );

  wire lossEdge = lockPrev & ~lockSync;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      lockPrev <= 1'b0;
      errPost <= 1'b0;
      errCode <= 10'h000;
      lossCount <= 8'h00;
    end
    else
    begin
      lockPrev <= lockSync;
      errPost <= lossEdge & unlockErrEnable;
      if (lossEdge & unlockErrEnable)
      begin
        errCode <= phase_lock_pkg::ERR_UNLOCKED;
      end
      if (lossEdge)
      begin
        lossCount <= lossCount + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_offset_in_range: assert property (
    (phaseRad <= phase_lock_pkg::TWO_PI_Q16) && (phaseRad >= -phase_lock_pkg::TWO_PI_Q16))
    else $error("phase offset outside two pi");

  a_ref_zeroes_phase: assert property (
    refTake |=> (relPhase == freqInc))
    else $error("reference did not zero present phase");

  a_ref_keeps_offset: assert property (
    refTake |=> $stable(phaseRad))
    else $error("reference changed phase offset");

  a_burst_independent: assert property (
    (wrTake & selBurst) |=> $stable(phaseRad))
    else $error("burst write changed phase offset");

  a_offset_not_burst: assert property (
    phaseWr |=> $stable(burstPhase))
    else $error("phase write changed burst phase");

  a_readback_radians: assert property (
    (take & avReq.read & selDeg) |-> (avRsp.readdata == radWord))
    else $error("degree address read not in radians");

  a_enable_readback: assert property (
    (take & avReq.read & selCtrl) |-> (avRsp.readdata[1:0] == {1'b0, unlockErrEnable}))
    else $error("enable readback wrong");

  a_error_on_loss: assert property (
    (lockPrev & ~lockSync & unlockErrEnable) |=> (errPost && errCode == 10'h244))
    else $error("unlock error not posted");

  a_error_once: assert property (
    errPost |-> ($past(lockPrev) && !$past(lockSync)) ##1 !errPost)
    else $error("unlock error repeated");

  a_error_gated: assert property (
    errPost |-> $past(unlockErrEnable))
    else $error("error posted while disabled");

  a_no_option: assert property (
    !OPTION_FITTED |-> (phaseRad == 20'sh00000 && !unlockErrEnable && !errPost))
    else $error("phase function active without option");

  a_answer_next: assert property (
    (busReq & avRsp.waitrequest) |=> !avRsp.waitrequest)
    else $error("bus answer late");

  c_ref_cmd: cover property (refTake);
  c_deg_write: cover property (phaseWr & selDeg);
  c_unlock_err: cover property (errPost);
  c_loss_silent: cover property (lossEdge & ~unlockErrEnable);
endmodule // phase_offset_lock_monitor

// file: common/phase_lock_pkg.sv
package phase_lock_pkg;
  typedef struct packed
  {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed
  {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_t;

  typedef enum logic [2:0]
  {
    WAVE_SINE = 3'b000,
    WAVE_SQUARE = 3'b001,
    WAVE_TRI = 3'b010,
    WAVE_RAMP = 3'b011,
    WAVE_ARB = 3'b100
  } wave_kind_t;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PHASE_RAD = 8'h04;
  localparam logic [7:0] OFF_PHASE_DEG = 8'h08;
  localparam logic [7:0] OFF_BURST_PHASE = 8'h0C;
  localparam logic [7:0] OFF_FREQ_INC = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam int CTRL_UNLOCK_EN_BIT = 0;
  localparam int CTRL_REF_BIT = 1;
  localparam int CTRL_KIND_LSB = 2;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_OPTION_BIT = 1;
  localparam int STAT_LOSS_LSB = 8;

  localparam logic RST_UNLOCK_EN = 1'b0;
  localparam logic signed [19:0] RST_PHASE_RAD = 20'sh00000;
  localparam logic signed [9:0] RST_BURST_PHASE = 10'sh000;
  localparam logic [31:0] RST_FREQ_INC = 32'h00000000;

  localparam logic signed [19:0] TWO_PI_Q16 = 20'sh6487F;
  localparam logic [12:0] RAD_PER_DEG_Q16 = 13'h0478;
  localparam logic [14:0] TURN_PER_RAD = 15'h28BE;
  localparam logic [9:0] ERR_UNLOCKED = 10'h244;
endpackage

// file: design/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // System clock
  input wire logic nrst, // Sync reset, active low
  input wire logic [WIDTH-1:0] din, // Asynchronous level
  output logic [WIDTH-1:0] dout // Synchronised level
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // sync2

// file: design/phase_convert.sv
`timescale 1ns/1ps
module phase_convert (
  input wire logic [31:0] word, // Written value
  input wire logic isDeg, // Value given in degrees Q8
  output logic signed [19:0] rad // Radians Q16, clamped
);
  localparam logic signed [39:0] LIM = 40'(phase_lock_pkg::TWO_PI_Q16);
  logic signed [31:0] inWord;
  logic signed [44:0] degProd;
  logic signed [39:0] raw;

  assign inWord = signed'(word);
  assign degProd = inWord * $signed({1'b0, phase_lock_pkg::RAD_PER_DEG_Q16});
  // Out-of-range values saturate, so MIN and MAX land on the range ends
  assign raw = isDeg ? 40'(degProd >>> 8) : 40'(inWord);
  assign rad = (raw > LIM) ? phase_lock_pkg::TWO_PI_Q16
             : (raw < -LIM) ? -phase_lock_pkg::TWO_PI_Q16
             : raw[19:0];
endmodule // phase_convert

// file: bench/pll_model.sv
`timescale 1ns/1ps
module pll_model (
  input wire logic clock, // System clock
  input wire logic wantLock, // Requested loop state
  output logic lockDetect // Lock pin, high when locked
);
  logic [2:0] settle = 3'h0;
  initial lockDetect = 1'b0;
  // Loop needs a few cycles to settle either way, like a real one
  always @(posedge clock)
  begin
    settle <= (lockDetect == wantLock) ? 3'h0 : settle + 3'h1;
    if (settle == 3'h4)
      lockDetect <= wantLock;
  end
endmodule // pll_model

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic wantLock = 1'b0;
  logic lockDetect;
  phase_lock_pkg::avmm_req_t avReq = '0;
  phase_lock_pkg::avmm_rsp_t avRsp;
  logic [31:0] wavePhase;
  logic [13:0] arbAddr;
  logic signed [11:0] sample;
  phase_lock_pkg::wave_kind_t waveKind;
  logic signed [9:0] burstPhase;
  logic errPost;
  logic [9:0] errCode;
  int failures = 0;
  int tests_run = 0;
  int posts = 0;
  int mPosts = 0;
  int mEn = 0;
  int mKind = 0;
  int mLoss = 0;
  int v;
  logic [31:0] rng = 32'hE1CD;
  logic [31:0] q;
  logic [31:0] offIn [6] = '{32'h00010000, 32'h00070000, 32'hFFF90000, 32'h0002D000,
    32'hFFFD3000, 32'h00000000};
  logic [31:0] offExp [6] = '{32'h00010000, 32'h0006487F, 32'hFFF9B781, 32'h0006487F,
    32'hFFF9B781, 32'h00000000};

  always #2 clock = ~clock;
  always @(posedge clock)
    if (errPost === 1'b1)
      posts <= posts + 1;

  phase_offset_lock_monitor #(.OPTION_FITTED(1'b1)) u_phase_offset_lock_monitor (
    .clock(clock), .nrst(nrst), .avReq(avReq), .avRsp(avRsp), .lockDetect(lockDetect),
    .wavePhase(wavePhase), .arbAddr(arbAddr), .sample(sample), .waveKind(waveKind),
    .burstPhase(burstPhase), .errPost(errPost), .errCode(errCode));
  pll_model u_pll_model (.clock(clock), .wantLock(wantLock), .lockDetect(lockDetect));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avReq.address <= a;
    avReq.read <= ~wr;
    avReq.write <= wr;
    avReq.writedata <= d;
    avReq.byteenable <= 4'hF;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avRsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      failures++;
    q = avRsp.readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    // Idle edge so a following request never lands in the release step
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] clampRad(input int a);
    int t;
    t = int'(phase_lock_pkg::TWO_PI_Q16);
    return 32'((a > t) ? t : (a < -t) ? -t : a);
  endfunction

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(phase_lock_pkg::OFF_CTRL, 32'h0, "ctrl");
    rd(phase_lock_pkg::OFF_PHASE_RAD, 32'h0, "offset");
    chk("errCode", 32'h0, 32'(errCode));
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, (i > 2) ? phase_lock_pkg::OFF_PHASE_DEG : phase_lock_pkg::OFF_PHASE_RAD,
        offIn[i]);
      rd(phase_lock_pkg::OFF_PHASE_RAD, offExp[i], "offset");
      rd(phase_lock_pkg::OFF_PHASE_DEG, offExp[i], "offsetDeg");
    end
    repeat (8)
    begin
      rng = nxt(rng);
      v = int'(rng % 32'(phase_lock_pkg::TWO_PI_Q16));
      if (rng[31])
        v = -v;
      xfer(1'b1, phase_lock_pkg::OFF_PHASE_RAD, 32'(v));
      rd(phase_lock_pkg::OFF_PHASE_RAD, clampRad(v), "offsetRand");
    end
    for (int k = 0; k < 6; k++)
    begin
      xfer(1'b1, phase_lock_pkg::OFF_CTRL, 32'(k * 4));
      if (k < 5)
        mKind = k;
      chk("waveKind", 32'(mKind), 32'(waveKind));
      rd(phase_lock_pkg::OFF_CTRL, 32'(mKind * 4), "ctrlKind");
    end
    xfer(1'b1, phase_lock_pkg::OFF_BURST_PHASE, 32'h0000005A);
    chk("burstPhase", 32'h0000005A, 32'(burstPhase));
    xfer(1'b1, phase_lock_pkg::OFF_PHASE_RAD, 32'h00008000);
    rd(phase_lock_pkg::OFF_BURST_PHASE, 32'h0000005A, "burst");
    xfer(1'b1, phase_lock_pkg::OFF_BURST_PHASE, 32'h0000002D);
    rd(phase_lock_pkg::OFF_PHASE_RAD, 32'h00008000, "offset");
    // Freeze the accumulator away from zero, then take it as the new zero
    xfer(1'b1, phase_lock_pkg::OFF_PHASE_RAD, 32'h00010000);
    xfer(1'b1, phase_lock_pkg::OFF_FREQ_INC, nxt(rng) | 32'h00000001);
    repeat (10) @(posedge clock);
    xfer(1'b1, phase_lock_pkg::OFF_FREQ_INC, 32'h0);
    xfer(1'b1, phase_lock_pkg::OFF_CTRL, 32'(mKind * 4 + 2));
    rd(phase_lock_pkg::OFF_PHASE_RAD, 32'h00010000, "offsetRef");
    rd(phase_lock_pkg::OFF_CTRL, 32'(mKind * 4), "ctrlRef");
    xfer(1'b1, phase_lock_pkg::OFF_PHASE_RAD, 32'h0);
    repeat (3) @(posedge clock);
    chk("wavePhase", 32'h0, wavePhase);
    chk("arbAddr", 32'h0, 32'(arbAddr));
    xfer(1'b1, phase_lock_pkg::OFF_PHASE_RAD, 32'h00010000);
    mKind = 1;
    xfer(1'b1, phase_lock_pkg::OFF_CTRL, 32'(mKind * 4));
    repeat (3) @(posedge clock);
    q = 32'h00010000 * 32'(phase_lock_pkg::TURN_PER_RAD);
    chk("wavePhaseOff", q, wavePhase);
    chk("arbAddrOff", 32'(q[31:18]), 32'(arbAddr));
    chk("sampleSquare", 32'(12'sh7FF), 32'(sample));
    for (int i = 0; i < 3; i++)
    begin
      mEn = (i != 1);
      xfer(1'b1, phase_lock_pkg::OFF_CTRL, 32'(mKind * 4 + mEn));
      wantLock <= 1'b1;
      repeat (20) @(posedge clock);
      rd(phase_lock_pkg::OFF_STATUS, 32'(mLoss * 256 + 3), "statusLocked");
      wantLock <= 1'b0;
      repeat (40) @(posedge clock);
      mLoss++;
      mPosts += mEn;
      chk("posts", 32'(mPosts), 32'(posts));
      rd(phase_lock_pkg::OFF_STATUS, 32'(mLoss * 256 + 2), "status");
      rd(phase_lock_pkg::OFF_CTRL, 32'(mKind * 4 + mEn), "ctrlEn");
    end
    chk("errCode", 32'h00000244, 32'(errCode));
    // Second reset: volatile settings fall back to defaults
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    mKind = 0;
    mEn = 0;
    rd(phase_lock_pkg::OFF_PHASE_RAD, 32'h0, "offsetReset");
    rd(phase_lock_pkg::OFF_CTRL, 32'h0, "ctrlReset");
    chk("errCodeReset", 32'h0, 32'(errCode));
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, "unmapped");
    rd(phase_lock_pkg::OFF_CTRL, 32'(mKind * 4 + mEn), "ctrlKept");
    tally_and_finish;
  end
endmodule // tb
